// ### core/anh_host.sv
// Notes on behaviour
// - Command latched on write rise, CLE high
// - Address latched on write rise, ALE high
// - User zeroes unused address bits; host sends address bytes unaltered
// - Sample on read rise; cycle >= 30ns
// - Reissue 00h after enhanced status
// - Change write protect only when idle
// - Wait 100us before first reset
// - Reset first; poll up to 1ms
// - No command within write-to-busy delay
// - Wait 100ns after write protect change
`timescale 1ns/10ps
`default_nettype none
`include "anh_map.svh"
module anh_host
	import anh_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// User request
	input  wire logic       req_valid,
	output logic            req_ready,
	input  wire logic [1:0] req_op,
	input  wire logic [7:0] req_data,
	input  wire logic       req_last,
	input  wire logic       wp_req,
	// User read data
	output logic            rd_valid,
	input  wire logic       rd_ready,
	output logic      [7:0] rd_data,
	// Status
	output logic            init_done,
	output logic            init_timeout,
	output logic            target_ready,
	// Flash pins
	output logic            chip_sel_n,
	output logic            cmd_latch,
	output logic            addr_latch,
	output logic            write_strobe_n,
	output logic            read_strobe_n,
	output logic            write_prot_n,
	output logic      [7:0] io_out,
	output logic            io_oe_n,
	input  wire logic [7:0] io_in,
	input  wire logic       rb_in
);
	localparam logic [19:0] C_WP    = 20'(`ANH_CYC_WP);
	localparam logic [19:0] C_WH    = 20'(`ANH_CYC_WH);
	localparam logic [19:0] C_RP    = 20'(`ANH_CYC_RP);
	localparam logic [19:0] C_REH   = 20'(`ANH_CYC_REH);
	localparam logic [19:0] C_WB    = 20'(`ANH_CYC_WB);
	localparam logic [19:0] C_WW    = 20'(`ANH_CYC_WW);
	localparam logic [19:0] C_WHR   = 20'(`ANH_CYC_WHR);
	localparam logic [19:0] C_PWRUP = 20'(`ANH_CYC_PWRUP);
	localparam logic [19:0] C_RSTMX = 20'(`ANH_CYC_RSTMAX);

	// -----------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------
	logic [7:0] io_s1_r, io_s2_r;
	logic       rb_s1_r, rb_s2_r;
	always_ff @(posedge clk)
	begin
		io_s1_r <= io_in;
		io_s2_r <= io_s1_r;
		rb_s1_r <= rb_in;
		rb_s2_r <= rb_s1_r;
	end

	// -----------------------------------------------------------
	// Read data FIFO
	// -----------------------------------------------------------
	logic       fifo_push, fifo_in_ready;
	logic [7:0] fifo_din;
	anh_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo
	(
		.clk       (clk),
		.reset     (reset),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_din),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

	// -----------------------------------------------------------
	// Sequencer
	// -----------------------------------------------------------
	anh_state_t  st_r, st_nxt;
	logic [19:0] cnt_r, cnt_nxt;
	anh_op_t     op_r, op_nxt;
	logic [7:0]  byte_r, byte_nxt;
	logic        last_r, last_nxt, wb_r, wb_nxt, done_r, done_nxt, tmo_r, tmo_nxt;
	logic        cs_n_r, cs_n_nxt, cle_r, cle_nxt, ale_r, ale_nxt;
	logic        we_n_r, we_n_nxt, rds_n_r, rds_n_nxt, wp_n_r, wp_n_nxt, oe_n_r, oe_n_nxt;
	logic        rdy_r, rdy_nxt;

	function automatic logic [19:0] dec(input logic [19:0] v);
		dec = (v == '0) ? '0 : 20'(v - 20'd1);
	endfunction

	always_comb
	begin
		st_nxt = st_r; cnt_nxt = dec(cnt_r); op_nxt = op_r; byte_nxt = byte_r;
		last_nxt = last_r; wb_nxt = wb_r; done_nxt = done_r; tmo_nxt = tmo_r;
		cs_n_nxt = cs_n_r; cle_nxt = cle_r; ale_nxt = ale_r; we_n_nxt = we_n_r;
		rds_n_nxt = rds_n_r; wp_n_nxt = wp_n_r; oe_n_nxt = oe_n_r;
		rdy_nxt = rb_s2_r;
		fifo_push = 1'b0;
		fifo_din = io_s2_r;
		req_ready = 1'b0;
		case (st_r)
			// Hold write protect low until supply has settled
			ANH_S_PWRUP:
				if (cnt_r == '0 && rb_s2_r)
				begin
					op_nxt = ANH_OP_CMD; byte_nxt = `ANH_CMD_RESET; last_nxt = 1'b1;
					cs_n_nxt = 1'b0; cle_nxt = 1'b1; cnt_nxt = C_WP;
					we_n_nxt = 1'b0; oe_n_nxt = 1'b0; st_nxt = ANH_S_WLOW;
				end
			// Ride out write-to-busy before trusting ready/busy
			ANH_S_RST_W:
				if (cnt_r == '0)
				begin
					cnt_nxt = C_RSTMX; st_nxt = ANH_S_RST_B;
				end
			ANH_S_RST_B:
				if (rb_s2_r)
				begin
					done_nxt = 1'b1; st_nxt = ANH_S_IDLE;
				end
				else if (cnt_r == '0)
				begin
					tmo_nxt = 1'b1; done_nxt = 1'b1; st_nxt = ANH_S_IDLE;
				end
			ANH_S_IDLE:
				if (wp_req != !wp_n_r && rb_s2_r && cs_n_r)
				begin
					wp_n_nxt = !wp_req; cnt_nxt = C_WW; st_nxt = ANH_S_WPSET;
				end
				else
				begin
					req_ready = 1'b1;
					if (req_valid)
					begin
						op_nxt = anh_op_t'(req_op); last_nxt = req_last;
						// Bytes go out unaltered: the user zeroes spare address bits
						byte_nxt = req_data;
						cs_n_nxt = 1'b0;
						cle_nxt = (anh_op_t'(req_op) == ANH_OP_CMD);
						ale_nxt = (anh_op_t'(req_op) == ANH_OP_ADDR);
						if (anh_op_t'(req_op) == ANH_OP_DOUT)
						begin
							oe_n_nxt = 1'b1; rds_n_nxt = 1'b0; cnt_nxt = C_RP;
							st_nxt = ANH_S_RLOW;
						end
						else
						begin
							oe_n_nxt = 1'b0; we_n_nxt = 1'b0; cnt_nxt = C_WP;
							st_nxt = ANH_S_WLOW;
						end
					end
				end
			ANH_S_WLOW:
				if (cnt_r == '0)
				begin
					we_n_nxt = 1'b1; cnt_nxt = C_WH; st_nxt = ANH_S_WHIGH;
					wb_nxt = (op_r == ANH_OP_CMD);
				end
			ANH_S_WHIGH:
				if (cnt_r == '0)
				begin
					cle_nxt = 1'b0; ale_nxt = 1'b0; oe_n_nxt = 1'b1;
					cs_n_nxt = last_r;
					cnt_nxt = wb_r ? C_WHR : '0;
					st_nxt = (!done_r) ? ANH_S_RST_W : ANH_S_GAP;
					if (!done_r)
						cnt_nxt = C_WB;
				end
			ANH_S_RLOW:
				// Sample at the rising edge; needs free FIFO space
				if (cnt_r == '0 && fifo_in_ready)
				begin
					rds_n_nxt = 1'b1; fifo_push = 1'b1; cnt_nxt = C_REH;
					st_nxt = ANH_S_GAP;
				end
			ANH_S_GAP:
				if (cnt_r == '0)
				begin
					wb_nxt = 1'b0;
					cs_n_nxt = last_r ? 1'b1 : cs_n_r;
					st_nxt = ANH_S_IDLE;
				end
			ANH_S_WPSET:
				if (cnt_r == '0)
					st_nxt = ANH_S_IDLE;
			default:
				st_nxt = ANH_S_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			st_r <= ANH_S_PWRUP; cnt_r <= C_PWRUP; op_r <= ANH_OP_CMD; byte_r <= 8'h00;
			last_r <= 1'b0; wb_r <= 1'b0; done_r <= 1'b0; tmo_r <= 1'b0;
			cs_n_r <= 1'b1; cle_r <= 1'b0; ale_r <= 1'b0; we_n_r <= 1'b1;
			rds_n_r <= 1'b1; wp_n_r <= 1'b0; oe_n_r <= 1'b1; rdy_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt; cnt_r <= cnt_nxt; op_r <= op_nxt; byte_r <= byte_nxt;
			last_r <= last_nxt; wb_r <= wb_nxt; done_r <= done_nxt; tmo_r <= tmo_nxt;
			cs_n_r <= cs_n_nxt; cle_r <= cle_nxt; ale_r <= ale_nxt; we_n_r <= we_n_nxt;
			rds_n_r <= rds_n_nxt; wp_n_r <= wp_n_nxt; oe_n_r <= oe_n_nxt; rdy_r <= rdy_nxt;
		end
	end

	// Pins straight from flops
	assign chip_sel_n     = cs_n_r;
	assign cmd_latch      = cle_r;
	assign addr_latch     = ale_r;
	assign write_strobe_n = we_n_r;
	assign read_strobe_n  = rds_n_r;
	assign write_prot_n   = wp_n_r;
	assign io_out         = byte_r;
	assign io_oe_n        = oe_n_r;
	assign init_done      = done_r;
	assign init_timeout   = tmo_r;
	assign target_ready   = rdy_r;

	// -----------------------------------------------------------
	// Checks
	// -----------------------------------------------------------
	a_cmd_levels: assert property (@(posedge clk) disable iff (reset)
		$rose(we_n_r) && cle_r |-> !cs_n_r && !ale_r && rds_n_r)
		else $error("command strobe with bad latch levels");
	a_addr_levels: assert property (@(posedge clk) disable iff (reset)
		$rose(we_n_r) && ale_r |-> !cs_n_r && !cle_r && rds_n_r)
		else $error("address strobe with bad latch levels");
	a_read_levels: assert property (@(posedge clk) disable iff (reset)
		$fell(rds_n_r) |-> !cs_n_r && !cle_r && !ale_r && we_n_r && oe_n_r)
		else $error("read strobe with bad levels");
	a_first_reset: assert property (@(posedge clk) disable iff (reset)
		$rose(cle_r) && !done_r |-> byte_r == `ANH_CMD_RESET)
		else $error("first command is not reset");
	a_wp_quiet: assert property (@(posedge clk) disable iff (reset)
		$changed(wp_n_r) |-> $past(cs_n_r) && $past(st_r) == ANH_S_IDLE)
		else $error("write protect changed outside idle");
	a_wp_settle: assert property (@(posedge clk) disable iff (reset)
		$changed(wp_n_r) |-> we_n_r [*8] ##1 we_n_r [*5])
		else $error("strobe too soon after write protect change");
	// Twelve cycles after the strobe rise are checked, one short of the write-to-busy span
	a_cmd_wb: assert property (@(posedge clk) disable iff (reset)
		$rose(we_n_r) && cle_r |=> !(st_r == ANH_S_IDLE && req_ready) [*8]
		##1 !(st_r == ANH_S_IDLE && req_ready) [*4])
		else $error("new request within write-to-busy delay");
	a_strobe_width: assert property (@(posedge clk) disable iff (reset)
		$fell(rds_n_r) |-> !rds_n_r [*2])
		else $error("read pulse too short");
	c_reset_done: cover property (@(posedge clk) $rose(done_r));
	c_read_byte: cover property (@(posedge clk) fifo_push);
	c_wp_change: cover property (@(posedge clk) $changed(wp_n_r));
endmodule
`default_nettype wire

// ### common/anh_map.svh
`ifndef ANH_MAP_SVH
`define ANH_MAP_SVH
// Clock period in ps
`define ANH_CLK_PS          8000
// Strobe timing, ns as printed
`define ANH_T_WP_NS         15
`define ANH_T_WH_NS         10
`define ANH_T_RP_NS         15
`define ANH_T_REH_NS        10
`define ANH_T_WB_NS         100
`define ANH_T_WW_NS         100
`define ANH_T_WHR_NS        80
// Power-up and reset waits, us and ms as printed
`define ANH_T_PWRUP_US      100
`define ANH_T_RSTMAX_MS     1
// Derived cycle counts: least times round up
`define ANH_CYC_UP(ns)      ((((ns) * 1000) + `ANH_CLK_PS - 1) / `ANH_CLK_PS)
`define ANH_CYC_WP          `ANH_CYC_UP(`ANH_T_WP_NS)
`define ANH_CYC_WH          `ANH_CYC_UP(`ANH_T_WH_NS)
`define ANH_CYC_RP          `ANH_CYC_UP(`ANH_T_RP_NS)
`define ANH_CYC_REH         `ANH_CYC_UP(`ANH_T_REH_NS)
`define ANH_CYC_WB          `ANH_CYC_UP(`ANH_T_WB_NS)
`define ANH_CYC_WW          `ANH_CYC_UP(`ANH_T_WW_NS)
`define ANH_CYC_WHR         `ANH_CYC_UP(`ANH_T_WHR_NS)
`define ANH_CYC_PWRUP       ((`ANH_T_PWRUP_US * 1000000 + `ANH_CLK_PS - 1) / `ANH_CLK_PS)
`define ANH_CYC_RSTMAX      ((`ANH_T_RSTMAX_MS * 1000000000) / `ANH_CLK_PS)
// Command codes
`define ANH_CMD_READ_MODE   8'h00
`define ANH_CMD_STATUS      8'h70
`define ANH_CMD_STATUS_ENH  8'h78
`define ANH_CMD_READ_ID     8'h90
`define ANH_CMD_RESET       8'hff
// Status bit: ready
`define ANH_ST_RDY_BIT      6
`endif

// ### common/anh_pkg.sv
package anh_pkg;
	// Host request kinds
	typedef enum logic [1:0]
	{
		ANH_OP_CMD  = 2'b00,
		ANH_OP_ADDR = 2'b01,
		ANH_OP_DIN  = 2'b10,
		ANH_OP_DOUT = 2'b11
	} anh_op_t;

	// Sequencer states
	typedef enum logic [3:0]
	{
		ANH_S_PWRUP = 4'h0,
		ANH_S_RST_W = 4'h1,
		ANH_S_RST_B = 4'h2,
		ANH_S_IDLE  = 4'h3,
		ANH_S_WLOW  = 4'h4,
		ANH_S_WHIGH = 4'h5,
		ANH_S_RLOW  = 4'h6,
		ANH_S_RHIGH = 4'h7,
		ANH_S_GAP   = 4'h8,
		ANH_S_WPSET = 4'h9
	} anh_state_t;
endpackage

// ### core/anh_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module anh_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             push, pop;

	// -----------------------------------------------------------
	// Pointer and count update
	// -----------------------------------------------------------
	always_comb
	begin
		push    = in_valid && in_ready;
		pop     = out_valid && out_ready;
		wr_nxt  = push ? AW'(wr_r + 1'b1) : wr_r;
		rd_nxt  = pop ? AW'(rd_r + 1'b1) : rd_r;
		cnt_nxt = AW'(0) + cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wr_r  <= wr_nxt;
			rd_r  <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage has no reset; contents are guarded by count
	always_ff @(posedge clk)
	begin
		if (push)
			mem_r[wr_r] <= in_data;
	end

	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rd_r];
endmodule
`default_nettype wire

// ### tb/anh_nand_model.sv
`timescale 1ns/10ps
`default_nettype none
// --------------------------------------------------------------
// Behavioural flash target on the far side of the host
// --------------------------------------------------------------
module anh_nand_model
#(
	parameter int          FIRST_NS = 4000,
	parameter int          LATER_NS = 1000,
	parameter int          PWRUP_NS = 2000,
	parameter logic [39:0] ID_CODE  = 40'h5aa53cc311 // Arbitrary value
)
(
	// Host pins
	input  wire logic       chip_sel_n,
	input  wire logic       cmd_latch,
	input  wire logic       addr_latch,
	input  wire logic       write_strobe_n,
	input  wire logic       read_strobe_n,
	input  wire logic       write_prot_n,
	input  wire logic [7:0] dq_in,
	// Device drive
	output logic      [7:0] dq_out,
	output logic            dq_oe,
	output logic            rb_low,
	output logic      [7:0] first_cmd
);
	logic       busy = 1'b1;
	logic       stat_m = 1'b0;
	logic       id_m = 1'b0;
	logic       seen = 1'b0;
	logic       rst_done = 1'b0;
	logic       drv;
	logic [7:0] id_sel = 8'h00;
	logic [7:0] v;
	logic [7:0] cache [16];
	int         ptr = 0;
	int         rst_t = 0;
	event       rst_go;
	// Busy through power-up so the host must wait for ready
	initial
	begin
		dq_out = 8'h00;
		dq_oe = 1'b0;
		first_cmd = 8'h00;
		#PWRUP_NS busy = 1'b0;
	end
	assign rb_low = busy;
	// Reset busy span starts shortly after the write strobe rises
	always @(rst_go)
	begin
		#50 busy = 1'b1;
		#rst_t busy = 1'b0;
	end
	task automatic do_cmd(input logic [7:0] c);
		if (!seen)
			first_cmd = c;
		seen = 1'b1;
		if (c == 8'hff)
		begin
			stat_m = 1'b0;
			id_m = 1'b0;
			ptr = 0;
			rst_t = rst_done ? LATER_NS : FIRST_NS;
			rst_done = 1'b1;
			-> rst_go;
		end
		else if (c == 8'h70 || c == 8'h78)
			stat_m = 1'b1;
		else if (!busy)
		begin
			stat_m = 1'b0;
			id_m = (c == 8'h90);
			ptr = 0;
		end
	endtask
	function automatic logic [7:0] id_byte(input int i);
		logic [31:0] sig;
		sig = 32'h4f4e4649;
		if (id_sel == 8'h20)
			return (i < 4) ? sig[31-8*i -: 8] : 8'h00;
		return (i < 5) ? ID_CODE[39-8*i -: 8] : 8'h00;
	endfunction
	// Latch cycles; deselected cycles do nothing
	always @(posedge write_strobe_n)
		if (chip_sel_n === 1'b0 && read_strobe_n === 1'b1)
		begin
			if (cmd_latch && !addr_latch)
				do_cmd(dq_in);
			else if (addr_latch && !cmd_latch && (!busy || stat_m))
			begin
				id_sel = dq_in;
				ptr = 0;
			end
			else if (!cmd_latch && !addr_latch && !busy)
			begin
				cache[ptr[3:0]] = dq_in;
				ptr++;
			end
		end
	// Output on read fall; a busy die gives status only
	always @(negedge read_strobe_n)
		if (chip_sel_n === 1'b0 && !cmd_latch && !addr_latch && write_strobe_n === 1'b1)
		begin
			drv = stat_m || !busy;
			if (stat_m)
				v = {write_prot_n, !busy, !busy, 5'h00};
			else if (!busy)
			begin
				v = id_m ? id_byte(ptr) : cache[ptr[3:0]];
				ptr++;
			end
			#5 dq_out = v;
			dq_oe = drv;
		end
	// Hold time after the strobe, then the bus is let go
	always @(posedge read_strobe_n)
		dq_oe <= #15 1'b0;
	always @(posedge chip_sel_n)
		dq_oe = 1'b0;
endmodule
`default_nettype wire

// ### tb/async_nand_bus_reset_id_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "anh_map.svh"
// --------------------------------------------------------------
// Host sequencer bench
// --------------------------------------------------------------
module async_nand_bus_reset_id_tb
	import anh_pkg::*;
;
	typedef struct {logic [7:0] c; logic a; logic [7:0] ad; int n; logic [39:0] e;} anh_row_t;
	localparam logic [39:0] IDC = 40'h5aa53cc311;
	logic       clk, reset, req_valid, req_ready, req_last, wp_req, rd_valid, rd_ready;
	logic       init_done, init_timeout, target_ready, chip_sel_n, cmd_latch, addr_latch;
	logic       write_strobe_n, read_strobe_n, write_prot_n, io_oe_n, dq_oe, rb_low;
	logic [1:0] req_op;
	logic [7:0] req_data, rd_data, io_out, dq_out, last_v, first_cmd;
	logic [7:0] got [$];
	int         num_errors = 0;
	int         compares = 0;
	int         cyc;
	anh_row_t   rows [4] = '{'{8'h90, 1, 8'h00, 5, IDC}, '{8'h90, 1, 8'h20, 4, 40'h4f4e464900},
		'{8'h70, 0, 8'h00, 1, 40'he000000000}, '{8'h78, 1, 8'h00, 1, 40'he000000000}};
	// Undriven bus shows the inverse of its last value, never a lucky match
	wire        drv = io_oe_n === 1'b0 || dq_oe === 1'b1;
	wire  [7:0] bus_v = (io_oe_n === 1'b0) ? io_out : dq_out;
	wire  [7:0] io_in = drv ? bus_v : ~last_v;
	wire        rb_in = ~rb_low;
	always #4 clk = ~clk;
	always @(posedge clk)
		if (drv)
			last_v <= bus_v;
	// Sampled mid-cycle, where the drain handshake is settled
	always @(negedge clk)
		if (rd_valid === 1'b1 && rd_ready === 1'b1)
			got.push_back(rd_data);
	anh_host uut (.clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
		.req_op(req_op), .req_data(req_data), .req_last(req_last), .wp_req(wp_req),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .init_done(init_done),
		.init_timeout(init_timeout), .target_ready(target_ready), .chip_sel_n(chip_sel_n),
		.cmd_latch(cmd_latch), .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
		.read_strobe_n(read_strobe_n), .write_prot_n(write_prot_n), .io_out(io_out),
		.io_oe_n(io_oe_n), .io_in(io_in), .rb_in(rb_in));
	anh_nand_model #(.ID_CODE(IDC)) nand_dev (.chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch),
		.addr_latch(addr_latch), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
		.write_prot_n(write_prot_n), .dq_in(io_out), .dq_out(dq_out), .dq_oe(dq_oe),
		.rb_low(rb_low), .first_cmd(first_cmd));
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected %s exp %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected %s exp %b seen %b", nm, e, g);
		end
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	// Request held until the edge that sees ready
	task automatic req(input anh_op_t op, input logic [7:0] d, input logic last);
		int n;
		tick();
		req_valid = 1'b1;
		req_op = op;
		req_data = d;
		req_last = last;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (req_ready !== 1'b1 && n < 200000);
		chk1("req_ready", 1'b1, req_ready);
		tick();
		req_valid = 1'b0;
	endtask
	task automatic run(input logic [7:0] c, input logic a, input logic [7:0] ad, input int n);
		got.delete();
		req(ANH_OP_CMD, c, 1'b0);
		if (a)
			req(ANH_OP_ADDR, ad, 1'b0);
		for (int i = 0; i < n; i++)
			req(ANH_OP_DOUT, 8'h00, i == n - 1);
	endtask
	task automatic wait_got(input int n);
		int k;
		k = 0;
		while (got.size() < n && k < 3000)
		begin
			tick();
			k++;
		end
		chk1("got_count", 1'b1, got.size() >= n);
	endtask
	task automatic wait_rdy(input logic w);
		int k;
		k = 0;
		while (target_ready !== w && k < 5000)
		begin
			tick();
			k++;
		end
		chk1("target_ready", w, target_ready);
	endtask
	task automatic final_report();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Watchdog sized from power-up wait plus the test traffic
	initial
	begin
		#400000;
		num_errors++;
		final_report();
	end
	initial
	begin
		clk = 1'b0;
		reset = 1'b1;
		{req_valid, req_last, wp_req, req_op, req_data, last_v} = '0;
		rd_ready = 1'b1;
		repeat (3) @(posedge clk);
		#1 reset = 1'b0;
		chk1("init_done", 1'b0, init_done);
		chk1("chip_sel_n", 1'b1, chip_sel_n);
		chk1("write_prot_n", 1'b0, write_prot_n);
		chk1("io_oe_n", 1'b1, io_oe_n);
		chk1("cmd_latch", 1'b0, cmd_latch);
		chk1("addr_latch", 1'b0, addr_latch);
		chk1("write_strobe_n", 1'b1, write_strobe_n);
		chk1("read_strobe_n", 1'b1, read_strobe_n);
		cyc = 0;
		while (init_done !== 1'b1 && cyc < 20000)
		begin
			tick();
			cyc++;
		end
		chk1("init_wait", 1'b1, cyc >= `ANH_CYC_PWRUP);
		chk1("init_done", 1'b1, init_done);
		chk1("init_timeout", 1'b0, init_timeout);
		chk8("first_cmd", 8'hff, first_cmd);
		chk1("target_ready", 1'b1, target_ready);
		$display("test reset done");
		foreach (rows[r])
		begin
			run(rows[r].c, rows[r].a, rows[r].ad, rows[r].n);
			wait_got(rows[r].n);
			for (int i = 0; i < rows[r].n; i++)
				chk8("rd_data", rows[r].e[39-8*i -: 8], got[i]);
			repeat (4) tick();
			chk1("chip_sel_n", 1'b1, chip_sel_n);
			$display("test row %0d done", r);
		end
		// Nine bytes through a buffer of eight, drained late
		req(ANH_OP_CMD, 8'h00, 1'b0);
		for (int i = 0; i < 9; i++)
			req(ANH_OP_DIN, 8'(8'h11 * i + 1), i == 8);
		rd_ready = 1'b0;
		run(8'h00, 1'b0, 8'h00, 9);
		repeat (30) tick();
		chk1("read_strobe_n", 1'b0, read_strobe_n);
		chk1("rd_valid", 1'b1, rd_valid);
		rd_ready = 1'b1;
		wait_got(9);
		for (int i = 0; i < 9; i++)
			chk8("rd_data", 8'(8'h11 * i + 1), got[i]);
		$display("test fifo done");
		// Reset in mid-run, status while busy, then protect
		req(ANH_OP_CMD, 8'hff, 1'b1);
		run(8'h70, 1'b0, 8'h00, 1);
		wait_got(1);
		chk8("status", 8'h80, got[0]);
		wait_rdy(1'b0);
		wait_rdy(1'b1);
		run(8'h70, 1'b0, 8'h00, 1);
		wait_got(1);
		chk8("status", 8'he0, got[0]);
		wp_req = 1'b1;
		repeat (20) tick();
		chk1("write_prot_n", 1'b0, write_prot_n);
		req(ANH_OP_CMD, 8'hff, 1'b1);
		wait_rdy(1'b0);
		wait_rdy(1'b1);
		run(8'h70, 1'b0, 8'h00, 1);
		wait_got(1);
		chk8("status", 8'h60, got[0]);
		$display("test reset_wp done");
		final_report();
	end
endmodule
`default_nettype wire
